// *** verilog/six_channel_decimating_loader.sv ***
// Six-channel decimating loader with its word FIFO and transfer stage.
//
// Summary of operation
// R01: Ten-bit video word, bit nine most significant.
// R02: Edge-select high picks rising, low falling.
// R03: Sequence-begin seen high starts loading next edge.
// R04: Start channel zero, or five when direction high.
// R05: One word captured per successive active edge.
// R06: Step through six channels, then stop loading.
// R07: Transfer strobe detected on rising edges only.
// R08: Next rising edge moves held words to outputs.
// R09: All six outputs update together; holding freed.
// R10: Polarity captured on first rising edge after detection.
// R11: Captured polarity applied one transfer later.
// R12: High polarity above second reference, low below first.
`timescale 1ns/100ps

// ======================================================================
// Word FIFO with valid and ready on both sides.
module word_fifo #(
	parameter int unsigned WIDTH = loader_pkg::LOAD_W,
	parameter int unsigned DEPTH = loader_pkg::FIFO_DEPTH
) (
	// Clock, reset and enable.
	input  wire logic             sys_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             ce_i,
	// Filling side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W:0]   fill_q;
	logic             push;
	logic             pop;

	// Full and empty come straight from the fill count.
	assign in_ready_o  = (fill_q != DEPTH[PTR_W:0]);
	assign out_valid_o = (fill_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Storage has no reset; only the pointers and the fill count need a defined value.
	always_ff @(posedge sys_clk_i) begin
		if (ce_i && push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	// Pointers wrap naturally since the depth is a power of two.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fill_q   <= '0;
		end else if (ce_i) begin
			wr_ptr_q <= wr_ptr_q + PTR_W'(push);
			rd_ptr_q <= rd_ptr_q + PTR_W'(pop);
			fill_q   <= fill_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
		end
	end

endmodule

// ======================================================================
// Loader top level.
module six_channel_decimating_loader (
	// Clock, reset and enable.
	input  wire logic                           sys_clk_i,
	input  wire logic                           rstn_i,
	input  wire logic                           ce_i,
	// Timing controller inputs.
	input  wire logic                           video_clk_i,
	input  wire logic [loader_pkg::WORD_W-1:0]  video_word_in_i,
	input  wire logic                           sequence_begin_i,
	input  wire logic                           edge_select_i,
	input  wire logic                           direction_select_i,
	input  wire logic                           transfer_strobe_i,
	input  wire logic                           polarity_invert_i,
	// Loading status.
	output logic                                load_ready_o,
	// Output stage.
	output loader_pkg::chan_out_t               channel_outputs_o
);

	// ==================================================================
	// Video clock edges, sampled on the system clock.
	logic vclk_q;
	logic vclk_rise;
	logic vclk_fall;
	logic active_edge;

	// The video clock must stay at least two system cycles per phase.
	assign vclk_rise   = video_clk_i & ~vclk_q;
	assign vclk_fall   = ~video_clk_i & vclk_q;
	assign active_edge = edge_select_i ? vclk_rise : vclk_fall; // see R02

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			vclk_q <= 1'b0;
		end else if (ce_i) begin
			vclk_q <= video_clk_i;
		end
	end

	// ==================================================================
	// Loading sequencer.
	loader_pkg::seq_state_t          state_q;
	loader_pkg::seq_state_t          state_d;
	logic [loader_pkg::CHAN_W-1:0]   chan_q;
	logic [loader_pkg::CHAN_W-1:0]   count_q;
	logic                            down_q;
	logic                            starting;
	logic                            capture;
	logic                            last_word;
	logic                            step_down;
	logic [loader_pkg::CHAN_W-1:0]   start_chan;
	logic [loader_pkg::CHAN_W-1:0]   cap_chan;
	logic [loader_pkg::CHAN_W-1:0]   next_chan;
	loader_pkg::load_t               cap_entry;

	// A sequence opens on the active edge after the begin level is seen.
	assign starting   = active_edge & (state_q == loader_pkg::SEQ_ARMED);
	assign capture    = active_edge & (state_q != loader_pkg::SEQ_IDLE);
	assign start_chan = direction_select_i ? loader_pkg::CHAN_LAST
	                                       : loader_pkg::CHAN_FIRST; // see R04
	assign cap_chan   = starting ? start_chan : chan_q;
	assign step_down  = starting ? direction_select_i : down_q;
	assign next_chan  = step_down ? cap_chan - loader_pkg::CHAN_STEP
	                              : cap_chan + loader_pkg::CHAN_STEP; // see R06
	assign last_word  = ~starting & (count_q == loader_pkg::COUNT_LAST);
	assign cap_entry  = '{chan: cap_chan, word: video_word_in_i}; // see R01

	// Next state: a begin level always re-arms, even mid-sequence.
	always_comb begin
		state_d = state_q;
		if (active_edge) begin
			if (sequence_begin_i) begin
				state_d = loader_pkg::SEQ_ARMED; // see R03
			end else begin
				case (state_q)
					loader_pkg::SEQ_IDLE: begin
						state_d = loader_pkg::SEQ_IDLE;
					end
					loader_pkg::SEQ_ARMED: begin
						state_d = loader_pkg::SEQ_LOAD;
					end
					loader_pkg::SEQ_LOAD: begin
						state_d = last_word ? loader_pkg::SEQ_IDLE
						                    : loader_pkg::SEQ_LOAD; // see R06
					end
					default: begin
						state_d = loader_pkg::SEQ_IDLE;
					end
				endcase
			end
		end
	end

	// Channel pointer and word count advance once per captured word.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			state_q <= loader_pkg::SEQ_IDLE;
			chan_q  <= loader_pkg::CHAN_FIRST;
			count_q <= loader_pkg::COUNT_ZERO;
			down_q  <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			if (capture) begin
				chan_q  <= next_chan; // see R05
				count_q <= starting ? loader_pkg::COUNT_ONE
				                    : count_q + loader_pkg::COUNT_ONE;
				down_q  <= step_down;
			end
		end
	end

	// ==================================================================
	// Word FIFO between capture and the holding stages.
	logic                          fifo_out_valid;
	logic                          fifo_out_ready;
	logic [loader_pkg::LOAD_W-1:0] fifo_out_data;
	loader_pkg::load_t             drain_entry;

	// A capture while the FIFO is full is lost; load_ready_o warns of it.
	word_fifo #(
		.WIDTH(loader_pkg::LOAD_W),
		.DEPTH(loader_pkg::FIFO_DEPTH)
	) u_word_fifo (
		.sys_clk_i  (sys_clk_i),
		.rstn_i     (rstn_i),
		.ce_i       (ce_i),
		.in_valid_i (capture),
		.in_ready_o (load_ready_o),
		.in_data_i  (cap_entry),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o (fifo_out_data)
	);

	assign drain_entry = loader_pkg::load_t'(fifo_out_data);

	// ==================================================================
	// Transfer strobe detection and polarity pipeline.
	logic xfer_det_q;
	logic do_xfer;
	logic pol_cap_q;

	// Holding stages freeze between detection and transfer, so the
	// words moved out are exactly the ones held at detection time.
	assign fifo_out_ready = ~xfer_det_q;
	assign do_xfer        = vclk_rise & xfer_det_q; // see R08

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			xfer_det_q <= 1'b0;
		end else if (ce_i && vclk_rise) begin
			xfer_det_q <= transfer_strobe_i; // see R07
		end
	end

	// ==================================================================
	// Holding stages, one generate entry each.
	wire [loader_pkg::CHAN_COUNT-1:0][loader_pkg::WORD_W-1:0] held_words;

	for (genvar ch = 0; ch < loader_pkg::CHAN_COUNT; ch++) begin : g_chan
		logic [loader_pkg::WORD_W-1:0] hold_q;
		logic                          hit;

		assign hit = fifo_out_valid & fifo_out_ready &
		             (drain_entry.chan == loader_pkg::CHAN_W'(ch));
		assign held_words[ch] = hold_q;

		// A holding stage keeps its word until its channel comes round.
		always_ff @(posedge sys_clk_i) begin
			if (!rstn_i) begin
				hold_q <= loader_pkg::WORD_RESET;
			end else if (ce_i && hit) begin
				hold_q <= drain_entry.word;
			end
		end
	end

	// One process owns the whole output struct, so all six channels and
	// the applied polarity move on one edge; polarity is captured on the
	// transfer edge and lags the captured value by one transfer.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			pol_cap_q                          <= loader_pkg::POL_RESET;
			channel_outputs_o.word             <=
				{loader_pkg::CHAN_COUNT{loader_pkg::WORD_RESET}};
			channel_outputs_o.above_second_ref <= loader_pkg::POL_RESET;
		end else if (ce_i && do_xfer) begin
			pol_cap_q                          <= polarity_invert_i; // see R10
			channel_outputs_o.word             <= held_words; // see R09
			channel_outputs_o.above_second_ref <= pol_cap_q; // see R11 R12
		end
	end

endmodule

// *** verilog/loader_pkg.sv ***
// Shared constants and types for the six-channel decimating loader.
package loader_pkg;

	// ==================================================================
	// Widths and counts.
	localparam int unsigned WORD_W     = 10;
	localparam int unsigned CHAN_COUNT = 6;
	localparam int unsigned CHAN_W     = 3;
	localparam int unsigned FIFO_DEPTH = 16;

	// ==================================================================
	// Channel indices and loading counts.
	localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;
	localparam logic [CHAN_W-1:0] CHAN_LAST  = 3'h5;
	localparam logic [CHAN_W-1:0] CHAN_STEP  = 3'h1;
	localparam logic [CHAN_W-1:0] COUNT_ONE  = 3'h1;
	localparam logic [CHAN_W-1:0] COUNT_LAST = 3'h5;
	localparam logic [CHAN_W-1:0] COUNT_ZERO = 3'h0;

	// ==================================================================
	// Reset values.
	localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;
	localparam logic              POL_RESET  = 1'b0;

	// ==================================================================
	// Loading sequencer states, one-hot.
	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b001,
		SEQ_ARMED = 3'b010,
		SEQ_LOAD  = 3'b100
	} seq_state_t;

	// One captured word on its way to a holding stage.
	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [WORD_W-1:0] word;
	} load_t;

	localparam int unsigned LOAD_W = $bits(load_t);

	// The six channel words as driven to the output stage.
	typedef struct packed {
		logic [CHAN_COUNT-1:0][WORD_W-1:0] word;
		logic                              above_second_ref;
	} chan_out_t;

endpackage

// *** testbench/loader_chk.sv ***
// Concurrent checks on the ports of the six-channel loader.
`timescale 1ns/100ps

// ======================================================================
// Checker module.
module loader_chk (
	// Clock, reset and enable.
	input wire logic                  sys_clk_i,
	input wire logic                  rstn_i,
	input wire logic                  ce_i,
	// Timing controller inputs.
	input wire logic                  video_clk_i,
	input wire logic                  transfer_strobe_i,
	input wire logic                  polarity_invert_i,
	// Outputs.
	input wire logic                  load_ready_o,
	input wire loader_pkg::chan_out_t channel_outputs_o
);
	logic vclk_q;
	logic det_q;
	logic pol_q;
	// Edge decoding mirrors the design, so a high first sample is a rise.
	wire rise_c = ce_i && video_clk_i && !vclk_q;
	wire fall_c = ce_i && !video_clk_i && vclk_q;
	wire xfer_c = rise_c && det_q;

	// Shadow of strobe detection and the captured polarity stage.
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			vclk_q <= 1'b0;
			det_q  <= 1'b0;
			pol_q  <= 1'b0;
		end else if (ce_i) begin
			vclk_q <= video_clk_i;
			if (rise_c) det_q <= transfer_strobe_i;
			if (xfer_c) pol_q <= polarity_invert_i;
		end
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	// A transfer is a detection followed by the next rising edge.
	sequence s_detect;
		rise_c && transfer_strobe_i;
	endsequence
	sequence s_transfer;
		xfer_c;
	endsequence

	// A reset clears the outputs, so a change right after one is legal.
	a_out_only_xfer: assert property (
		$changed(channel_outputs_o) |->
		$past(xfer_c) || !$past(rstn_i))
		else $error("Outputs changed without a transfer.");
	a_pol_pipe: assert property (
		s_transfer |=>
		channel_outputs_o.above_second_ref == $past(pol_q))
		else $error("Applied polarity is not the one captured before.");
	a_pol_only_xfer: assert property (
		$changed(channel_outputs_o.above_second_ref) |->
		$past(xfer_c) || !$past(rstn_i))
		else $error("Polarity moved outside a transfer.");
	a_fall_ignored: assert property (
		(fall_c && transfer_strobe_i) |=> $stable(channel_outputs_o))
		else $error("Strobe acted on a falling edge.");
	a_no_detect_hold: assert property (
		(rise_c && !det_q) |=> $stable(channel_outputs_o))
		else $error("Transfer without a prior detection.");
	// The next rise is at least four cycles off, so two quiet cycles
	// after the new words show are always owed.
	a_xfer_settle: assert property (
		s_transfer ##1 1 |=> $stable(channel_outputs_o)[*2])
		else $error("Outputs moved again right after a transfer.");
	a_ce_freeze: assert property (
		!ce_i |=> $stable(channel_outputs_o))
		else $error("Outputs moved while the clock enable was low.");
	a_reset_clear: assert property (
		$rose(rstn_i) |-> channel_outputs_o == '0 && load_ready_o)
		else $error("Outputs or ready wrong after reset.");
endmodule

bind six_channel_decimating_loader loader_chk loader_chk_inst (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
	.video_clk_i(video_clk_i), .transfer_strobe_i(transfer_strobe_i),
	.polarity_invert_i(polarity_invert_i), .load_ready_o(load_ready_o),
	.channel_outputs_o(channel_outputs_o)
);

// *** testbench/tcon_model.sv ***
// Timing controller model driving video words, clock and strobes.
`timescale 1ns/100ps

// ======================================================================
// Controller model.
module tcon_model (
	// Clock.
	input  wire logic                     sys_clk_i,
	// Controller outputs.
	output logic                          video_clk_o,
	output logic [loader_pkg::WORD_W-1:0] video_word_o,
	output logic                          sequence_begin_o,
	output logic                          transfer_strobe_o,
	output logic                          polarity_invert_o
);
	// Quiet levels at time zero.
	initial begin
		video_clk_o       = 1'b0;
		video_word_o      = 10'h000;
		sequence_begin_o  = 1'b0;
		transfer_strobe_o = 1'b0;
		polarity_invert_o = 1'b0;
	end

	// One video period: values stand over both edges, so either edge sees
	// them; the low phase lasts three cycles to give the drain slack.
	task automatic vper(input logic [loader_pkg::WORD_W-1:0] w,
		input logic b, input logic s, input logic p);
		@(posedge sys_clk_i);
		video_clk_o       <= 1'b1;
		video_word_o      <= w;
		sequence_begin_o  <= b;
		transfer_strobe_o <= s;
		polarity_invert_o <= p;
		repeat (2) @(posedge sys_clk_i);
		video_clk_o <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
	endtask
endmodule

// *** testbench/six_channel_decimating_loader_tb.sv ***
// Self-checking testbench for the six-channel loader.
`timescale 1ns/100ps

// ======================================================================
// Testbench top.
module six_channel_decimating_loader_tb;
	logic                  sys_clk  = 1'b0;
	logic                  rstn     = 1'b0;
	logic                  ce       = 1'b1;
	logic                  edge_sel = 1'b1;
	logic                  dir_sel  = 1'b0;
	logic                  vclk;
	logic [9:0]            vword;
	logic                  sbegin;
	logic                  strobe;
	logic                  pol;
	logic                  load_ready;
	loader_pkg::chan_out_t chan_out;
	int                    failures  = 0;
	int                    tests_run = 0;

	// Free-running system clock.
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	six_channel_decimating_loader six_channel_decimating_loader_inst (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(ce),
		.video_clk_i(vclk), .video_word_in_i(vword),
		.sequence_begin_i(sbegin), .edge_select_i(edge_sel),
		.direction_select_i(dir_sel), .transfer_strobe_i(strobe),
		.polarity_invert_i(pol), .load_ready_o(load_ready),
		.channel_outputs_o(chan_out)
	);

	tcon_model tcon_model_inst (
		.sys_clk_i(sys_clk), .video_clk_o(vclk), .video_word_o(vword),
		.sequence_begin_o(sbegin), .transfer_strobe_o(strobe),
		.polarity_invert_o(pol)
	);

	// Compare one value and count the outcome.
	task automatic chk(input string name, input logic [9:0] got,
		input logic [9:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Detect on one rise, transfer on the next; p is sampled then.
	task automatic transfer(input logic p);
		tcon_model_inst.vper(10'h000, 1'b0, 1'b1, 1'b0);
		tcon_model_inst.vper(10'h000, 1'b0, 1'b0, p);
		@(negedge sys_clk);
	endtask

	// Print the counts and the verdict, then stop.
	task automatic results;
		$display("Checks run %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence; words seven to nine must not land anywhere: a
	// pointer that kept stepping would wrap the ninth into channel zero.
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk("ready", {9'h000, load_ready}, 10'h001);
		tcon_model_inst.vper(10'h000, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 9; i++) begin
			tcon_model_inst.vper(10'h155 ^ 10'(i), 1'b0, 1'b0, 1'b0);
		end
		transfer(1'b1);
		for (int i = 0; i < 6; i++) begin
			chk("up word", chan_out.word[i], 10'h155 ^ 10'(i));
		end
		chk("pol first", {9'h000, chan_out.above_second_ref}, 10'h000);
		// Descending sequence loaded on falling edges.
		@(posedge sys_clk);
		edge_sel <= 1'b0;
		dir_sel  <= 1'b1;
		tcon_model_inst.vper(10'h000, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			tcon_model_inst.vper(10'h2AA ^ 10'(i), 1'b0, 1'b0, 1'b0);
		end
		transfer(1'b0);
		for (int i = 0; i < 6; i++) begin
			chk("down word", chan_out.word[5-i], 10'h2AA ^ 10'(i));
		end
		chk("pol high", {9'h000, chan_out.above_second_ref}, 10'h001);
		transfer(1'b0);
		chk("pol low", {9'h000, chan_out.above_second_ref}, 10'h000);
		chk("kept word", chan_out.word[0], 10'h2AF);
		// Two transfers with the enable low would apply polarity one if
		// the freeze leaked; then a second reset in mid-run.
		@(posedge sys_clk);
		ce <= 1'b0;
		transfer(1'b1);
		transfer(1'b1);
		chk("frozen pol", {9'h000, chan_out.above_second_ref}, 10'h000);
		@(posedge sys_clk);
		ce   <= 1'b1;
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk("reset word", chan_out.word[5], 10'h000);
		chk("ready again", {9'h000, load_ready}, 10'h001);
		results();
	end

	// Watchdog well beyond the roughly 145 cycles the run needs.
	initial begin
		repeat (3000) @(posedge sys_clk);
		failures++;
		results();
	end
endmodule
